// ---- bgm_pkg.sv ----
// Shared constants and types for the battery gauge measurement core.
// Assumes a single 10 MHz clock and a synchronous active-low reset.
package bgm_pkg;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int CLK_HZ         = 10_000_000;
	localparam int TICK_HZ        = 32768;
	localparam int TICK_DIV       = CLK_HZ / TICK_HZ;
	localparam int CYCLE_S        = 4;
	localparam int TEMP_S         = 16;
	localparam int TEMP_EVERY     = TEMP_S / CYCLE_S;
	localparam int PERIOD_TICKS   = TICK_HZ * CYCLE_S;
	localparam int VT_CONV_TICKS  = 8192;
	localparam int CUR_CONV_MS    = 500;
	localparam int CUR_CONV_TICKS = TICK_HZ * CUR_CONV_MS / 1000;

	// ********************************************************
	// Register addresses (five-bit register port)
	// ********************************************************
	localparam logic [4:0] ADDR_MODE   = 5'h00;
	localparam logic [4:0] ADDR_CHARGE = 5'h01;
	localparam logic [4:0] ADDR_CC_CNF = 5'h02;
	localparam logic [4:0] ADDR_VM_CNF = 5'h03;
	localparam logic [4:0] ADDR_VOLT   = 5'h04;
	localparam logic [4:0] ADDR_TEMP   = 5'h05;
	localparam logic [4:0] ADDR_CUR    = 5'h06;
	localparam logic [4:0] ADDR_ACC_LO = 5'h07;
	localparam logic [4:0] ADDR_ACC_HI = 5'h08;
	localparam logic [4:0] ADDR_COUNT  = 5'h09;
	localparam logic [4:0] ADDR_OCV    = 5'h0A;
	localparam logic [4:0] ADDR_CC_ADJ = 5'h0B;
	localparam logic [4:0] ADDR_VM_ADJ = 5'h0C;
	localparam logic [4:0] ADDR_ACC_CC = 5'h0D;
	localparam logic [4:0] ADDR_ACC_VM = 5'h0E;
	localparam int         TAB_BIT     = 4;

	// Mode register fields
	localparam int MODE_SEL_BIT = 0;
	localparam int CLR_CC_BIT   = 1;
	localparam int CLR_VM_BIT   = 2;
	localparam int METHOD_BIT   = 3;

	// Reset values
	localparam logic [15:0] CC_CNF_RST = 16'h018B;
	localparam logic [11:0] VM_CNF_RST = 12'h141;
	localparam logic        MODE_RST   = 1'b1;

	// Converter channel codes
	localparam logic [1:0] CH_VOLT = 2'h0;
	localparam logic [1:0] CH_TEMP = 2'h1;
	localparam logic [1:0] CH_CUR  = 2'h2;

	// Estimate tracking: step is one eighth of the error
	localparam int OCV_SHIFT = 3;

	typedef enum logic [1:0] {
		BGM_IDLE = 2'b00,
		BGM_VOLT = 2'b01,
		BGM_TEMP = 2'b10,
		BGM_CUR  = 2'b11
	} bgm_state_t;

endpackage

// ---- bgm_tick_gen.sv ----
// Divider giving a one-cycle enable at the internal time base rate.
// Assumes one system clock; rate error of the integer divide is tolerated.
`timescale 1ns/10ps
`default_nettype none
module bgm_tick_gen #(
	parameter int DIV = 305
) (
	input  wire logic clock, // System clock
	input  wire logic nrst,  // Synchronous reset, active low
	output logic      tick   // One-cycle time base enable
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} bgm_tick_t;

	bgm_tick_t r_ff;
	bgm_tick_t nxt_r;

	// Count down, pulse on wrap
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.tick = 1'b0;
		if (r_ff.cnt == 16'h0000)
		begin
			nxt_r.cnt = 16'(DIV - 1);
			nxt_r.tick = 1'b1;
		end
		else
		begin
			nxt_r.cnt = r_ff.cnt - 16'h0001;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			r_ff <= '0;
		else
			r_ff <= nxt_r;
	end

	assign tick = r_ff.tick;
endmodule
`default_nettype wire

// ---- bgm_conv_timer.sv ----
// Conversion window timer counting time base ticks.
// A start while busy restarts the window; the sequencer does so when a period start finds a current window still open.
`timescale 1ns/10ps
`default_nettype none
module bgm_conv_timer #(
	parameter int W = 17
) (
	input  wire logic         clock, // System clock
	input  wire logic         nrst,  // Synchronous reset, active low
	input  wire logic         tick,  // Time base enable
	input  wire logic         start, // Open a window
	input  wire logic [W-1:0] len,   // Window length in ticks
	output logic              busy,  // Window open
	output logic              done   // One-cycle end of window
);
	typedef struct packed {
		logic         busy;
		logic [W-1:0] cnt;
		logic         done;
	} bgm_timer_t;

	bgm_timer_t r_ff;
	bgm_timer_t nxt_r;

	// Done on the len-th tick after start
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.done = 1'b0;
		if (start)
		begin
			nxt_r.busy = 1'b1;
			nxt_r.cnt = len - 1'b1;
		end
		else if (r_ff.busy && tick)
		begin
			if (r_ff.cnt == '0)
			begin
				nxt_r.busy = 1'b0;
				nxt_r.done = 1'b1;
			end
			else
			begin
				nxt_r.cnt = r_ff.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!nrst)
			r_ff <= '0;
		else
			r_ff <= nxt_r;
	end

	assign busy = r_ff.busy;
	assign done = r_ff.done;
endmodule
`default_nettype wire

// ---- bgm_core.sv ----
// Gauge measurement core: conversion scheduling, coulomb bookkeeping
// and the gauge configuration and adjustment registers.
// Assumes the converter front end presents its result on adc_data
// in the cycle adc_end pulses, and that the algorithm datapath
// supplies the two state-of-charge estimates.
`timescale 1ns/10ps
`default_nettype none
module bgm_core #(
	parameter int          TICK_DIV     = bgm_pkg::TICK_DIV,
	parameter int          PERIOD_TICKS = bgm_pkg::PERIOD_TICKS,
	parameter int          VT_TICKS     = bgm_pkg::VT_CONV_TICKS,
	parameter int          CUR_TICKS    = bgm_pkg::CUR_CONV_TICKS,
	parameter int          ACC_W        = 32,
	parameter logic [13:0] HIGH_RATE    = 14'h0200
) (
	input  wire logic        clock,     // 10 MHz system clock
	input  wire logic        nrst,      // Synchronous reset, active low
	input  wire logic [4:0]  reg_addr,  // Register address
	input  wire logic        reg_wr,    // Write strobe
	input  wire logic [15:0] reg_wdata, // Write data
	output logic      [15:0] reg_rdata, // Read data, one cycle after address
	output logic             adc_start, // Conversion start pulse
	output logic      [1:0]  adc_ch,    // Channel of current conversion
	output logic             adc_end,   // Conversion end pulse
	input  wire logic [15:0] adc_data,  // Result, valid with adc_end
	input  wire logic [15:0] cc_soc,    // Coulomb method charge estimate
	input  wire logic [15:0] vm_soc     // Voltage method charge estimate
);
	// Period counter width, and the window lengths at that width
	localparam int PW = $clog2(PERIOD_TICKS);
	localparam logic [PW-1:0] PER_L = PW'(PERIOD_TICKS - 1);
	localparam logic [PW-1:0] VT_L  = PW'(VT_TICKS);
	localparam logic [PW-1:0] CUR_L = PW'(CUR_TICKS);
	localparam logic [1:0]    TMP_L = 2'(bgm_pkg::TEMP_EVERY - 1);

	// Whole state in one record; read data is registered too
	typedef struct packed {
		bgm_pkg::bgm_state_t st;
		logic [PW-1:0]       pcnt;
		logic [1:0]          frame;
		logic                mode_sel;
		logic                method_cc;
		logic [15:0]         cc_cnf;
		logic [11:0]         vm_cnf;
		logic [15:0]         charge;
		logic [11:0]         volt;
		logic [7:0]          temp;
		logic [13:0]         cur;
		logic [ACC_W-1:0]    acc;
		logic [15:0]         count;
		logic                ocv_ok;
		logic [11:0]         ocv;
		logic [15:0][7:0]    tab;
		logic [15:0]         cc_adj;
		logic [15:0]         vm_adj;
		logic [15:0]         acc_cc;
		logic [15:0]         acc_vm;
		logic                adc_start;
		logic [1:0]          adc_ch;
		logic [15:0]         rdata;
	} bgm_core_t;

	bgm_core_t r_ff;
	bgm_core_t nxt_r;

	// Combinational helpers of the next-state process
	logic          tick;
	logic          t_start;
	logic [PW-1:0] t_len;
	logic          t_done;
	logic          wrap;
	logic          go_next;
	logic          meth;
	logic [PW-1:0] rem;
	logic [13:0]   cmag;
	logic [12:0]   odiff;
	logic [12:0]   ostep;
	logic [11:0]   ocv_out;

	// ********************************************************
	// Time base and conversion window
	// ********************************************************
	bgm_tick_gen #(
		.DIV (TICK_DIV)
	) u_tick (
		.clock (clock),
		.nrst  (nrst),
		.tick  (tick)
	);

	bgm_conv_timer #(
		.W (PW)
	) u_timer (
		.clock (clock),
		.nrst  (nrst),
		.tick  (tick),
		.start (t_start),
		.len   (t_len),
		.busy  (),
		.done  (t_done)
	);

	// Corrected estimate seen by software
	assign ocv_out = 12'(r_ff.ocv + {{4{r_ff.tab[r_ff.ocv[11:8]][7]}},
		r_ff.tab[r_ff.ocv[11:8]]});

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.adc_start = 1'b0;
		t_start = 1'b0;
		t_len = CUR_L;
		go_next = 1'b0;
		meth = r_ff.method_cc;
		wrap = tick && (r_ff.pcnt == PER_L);
		rem = PER_L - r_ff.pcnt;
		// Rate of the result now ending; the most negative code stays large
		cmag = adc_data[13] ? 14'(-adc_data[13:0]) : adc_data[13:0];
		odiff = {1'b0, adc_data[11:0]} - {1'b0, r_ff.ocv};
		ostep = 13'($signed(odiff) >>> bgm_pkg::OCV_SHIFT);
		// Period position advances on every time base tick
		if (tick)
			nxt_r.pcnt = wrap ? '0 : r_ff.pcnt + 1'b1;

		// Software writes first so same-cycle hardware updates win
		if (reg_wr)
		begin
			if (reg_addr[bgm_pkg::TAB_BIT])
				nxt_r.tab[reg_addr[3:0]] = reg_wdata[7:0];
			else
			begin
				unique case (reg_addr)
					bgm_pkg::ADDR_MODE:
					begin
						nxt_r.mode_sel = reg_wdata[bgm_pkg::MODE_SEL_BIT];
						if (reg_wdata[bgm_pkg::CLR_CC_BIT])
							nxt_r.acc_cc = '0;
						if (reg_wdata[bgm_pkg::CLR_VM_BIT])
							nxt_r.acc_vm = '0;
					end
					bgm_pkg::ADDR_CHARGE:
					begin
						// Restart: new starting charge, counting from zero
						nxt_r.charge = reg_wdata;
						nxt_r.acc = '0;
						nxt_r.count = '0;
					end
					bgm_pkg::ADDR_CC_CNF: nxt_r.cc_cnf = reg_wdata;
					bgm_pkg::ADDR_VM_CNF: nxt_r.vm_cnf = reg_wdata[11:0];
					bgm_pkg::ADDR_CC_ADJ: nxt_r.cc_adj = reg_wdata;
					bgm_pkg::ADDR_VM_ADJ: nxt_r.vm_adj = reg_wdata;
					// Accumulators writable so software can seed them
					bgm_pkg::ADDR_ACC_CC: nxt_r.acc_cc = reg_wdata;
					bgm_pkg::ADDR_ACC_VM: nxt_r.acc_vm = reg_wdata;
					default: ;
				endcase
			end
		end

		// Conversion results
		if (t_done)
		begin
			unique case (r_ff.st)
				bgm_pkg::BGM_VOLT:
				begin
					nxt_r.volt = adc_data[11:0];
					nxt_r.ocv_ok = 1'b1;
					// Track toward the new reading; first one loads directly
					nxt_r.ocv = r_ff.ocv_ok ? 12'({1'b0, r_ff.ocv} + ostep)
						: adc_data[11:0];
					// Adjustments follow the two estimates at every voltage result
					nxt_r.cc_adj = vm_soc - cc_soc;
					nxt_r.vm_adj = cc_soc - vm_soc;
					if (r_ff.frame == 2'h0)
					begin
						nxt_r.st = bgm_pkg::BGM_TEMP;
						nxt_r.adc_ch = bgm_pkg::CH_TEMP;
						nxt_r.adc_start = 1'b1;
						t_start = 1'b1;
						t_len = VT_L;
					end
					else
						go_next = 1'b1;
				end
				bgm_pkg::BGM_TEMP:
				begin
					// Die temperature, signed whole degrees
					nxt_r.temp = adc_data[7:0];
					go_next = 1'b1;
				end
				bgm_pkg::BGM_CUR:
				begin
					// Not accumulated or counted if voltage-only mode was entered meanwhile
					if (!r_ff.mode_sel)
					begin
						nxt_r.acc = nxt_r.acc + ACC_W'($signed(adc_data[13:0]));
						nxt_r.count = nxt_r.count + 16'h0001;
						meth = cmag >= HIGH_RATE;
					end
					if (rem < CUR_L)
						nxt_r.cur = adc_data[13:0];
					go_next = 1'b1;
				end
				default: go_next = 1'b1;
			endcase
		end
		else if (r_ff.st == bgm_pkg::BGM_IDLE)
			go_next = 1'b1;

		// Fill the rest of the period with current conversions
		if (go_next)
		begin
			if (!nxt_r.mode_sel && rem >= CUR_L)
			begin
				nxt_r.st = bgm_pkg::BGM_CUR;
				nxt_r.adc_ch = bgm_pkg::CH_CUR;
				nxt_r.adc_start = 1'b1;
				t_start = 1'b1;
				t_len = CUR_L;
			end
			// Voltage-only mode, or too little of the period left
			else
				nxt_r.st = bgm_pkg::BGM_IDLE;
		end

		// Period start always opens a voltage slot
		if (wrap)
		begin
			nxt_r.frame = (r_ff.frame == TMP_L) ? 2'h0 : r_ff.frame + 2'h1;
			nxt_r.st = bgm_pkg::BGM_VOLT;
			nxt_r.adc_ch = bgm_pkg::CH_VOLT;
			nxt_r.adc_start = 1'b1;
			t_start = 1'b1;
			t_len = VT_L;
		end

		// Method choice; voltage-only mode forces the voltage method
		if (nxt_r.mode_sel)
			meth = 1'b0;
		nxt_r.method_cc = meth;
		if (meth != r_ff.method_cc)
		begin
			nxt_r.acc_cc = nxt_r.acc_cc + nxt_r.cc_adj;
			nxt_r.acc_vm = nxt_r.acc_vm + nxt_r.vm_adj;
		end

		// Read data, one cycle latency
		if (reg_addr[bgm_pkg::TAB_BIT])
			nxt_r.rdata = {{8{r_ff.tab[reg_addr[3:0]][7]}}, r_ff.tab[reg_addr[3:0]]};
		else
		begin
			unique case (reg_addr)
				bgm_pkg::ADDR_MODE:   nxt_r.rdata = 16'({r_ff.method_cc, 2'b00, r_ff.mode_sel});
				bgm_pkg::ADDR_CHARGE: nxt_r.rdata = r_ff.charge;
				bgm_pkg::ADDR_CC_CNF: nxt_r.rdata = r_ff.cc_cnf;
				bgm_pkg::ADDR_VM_CNF: nxt_r.rdata = {4'h0, r_ff.vm_cnf};
				bgm_pkg::ADDR_VOLT:   nxt_r.rdata = {4'h0, r_ff.volt};
				bgm_pkg::ADDR_TEMP:   nxt_r.rdata = {{8{r_ff.temp[7]}}, r_ff.temp};
				bgm_pkg::ADDR_CUR:    nxt_r.rdata = {{2{r_ff.cur[13]}}, r_ff.cur};
				bgm_pkg::ADDR_ACC_LO: nxt_r.rdata = r_ff.acc[15:0];
				bgm_pkg::ADDR_ACC_HI: nxt_r.rdata = r_ff.acc[31:16];
				bgm_pkg::ADDR_COUNT:  nxt_r.rdata = r_ff.count;
				bgm_pkg::ADDR_OCV:    nxt_r.rdata = {4'h0, ocv_out};
				bgm_pkg::ADDR_CC_ADJ: nxt_r.rdata = r_ff.cc_adj;
				bgm_pkg::ADDR_VM_ADJ: nxt_r.rdata = r_ff.vm_adj;
				bgm_pkg::ADDR_ACC_CC: nxt_r.rdata = r_ff.acc_cc;
				bgm_pkg::ADDR_ACC_VM: nxt_r.rdata = r_ff.acc_vm;
				default:              nxt_r.rdata = 16'h0000;
			endcase
		end
	end

	// ********************************************************
	// State register
	// ********************************************************
	// Period counter starts at its last value so the first voltage slot is at once
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			r_ff <= '0;
			r_ff.pcnt <= PER_L;
			r_ff.frame <= TMP_L;
			// Registers with non-zero reset values
			r_ff.mode_sel <= bgm_pkg::MODE_RST;
			r_ff.cc_cnf <= bgm_pkg::CC_CNF_RST;
			r_ff.vm_cnf <= bgm_pkg::VM_CNF_RST;
		end
		else
			r_ff <= nxt_r;
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	// Straight from flip-flops; adc_end is the timer's own flop
	assign reg_rdata = r_ff.rdata;
	assign adc_start = r_ff.adc_start;
	assign adc_ch    = r_ff.adc_ch;
	assign adc_end   = t_done;
endmodule
`default_nettype wire

// ---- bgm_props.sv ----
// Port checker for the gauge core, bound in at the foot.
// Assumes one clock and the package register map.
`timescale 1ns/10ps
`default_nettype none
module bgm_props #(
	parameter int TICK_DIV	= 4,
	parameter int VT_TICKS	= 16,
	parameter int CUR_TICKS	= 32
) (
	input wire logic	clock,		// Clock
	input wire logic	nrst,		// Reset, active low
	input wire logic [4:0]	reg_addr,	// Address
	input wire logic	reg_wr,		// Write strobe
	input wire logic [15:0]	reg_wdata,	// Write data
	input wire logic [15:0]	reg_rdata,	// Read data
	input wire logic	adc_start,	// Start pulse
	input wire logic [1:0]	adc_ch,		// Channel
	input wire logic	adc_end,	// End pulse
	input wire logic [15:0]	adc_data	// Result
);
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// ****************
	// Expected state
	// ****************
	localparam int VT_C = VT_TICKS * TICK_DIV;
	localparam int CU_C = CUR_TICKS * TICK_DIV;
	logic		mode_ff, cur_end, chg;
	logic [31:0]	age_ff, acc_ff;
	logic [15:0]	cnt_ff;
	logic [11:0]	volt_ff;
	assign cur_end = adc_end && adc_ch == bgm_pkg::CH_CUR && !mode_ff;
	assign chg = reg_wr && reg_addr == bgm_pkg::ADDR_CHARGE;
	// Mirror of the core; a restart clears before the same-cycle add
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			mode_ff <= 1'b1;
			age_ff <= 32'h0;
			acc_ff <= 32'h0;
			cnt_ff <= 16'h0;
			volt_ff <= 12'h0;
		end
		else
		begin
			if (reg_wr && reg_addr == bgm_pkg::ADDR_MODE)
				mode_ff <= reg_wdata[0];
			age_ff <= adc_start ? 32'h0 : age_ff + 32'h1;
			acc_ff <= (chg ? 32'h0 : acc_ff)
				+ (cur_end ? {{18{adc_data[13]}}, adc_data[13:0]} : 32'h0);
			cnt_ff <= (chg ? 16'h0 : cnt_ff) + {15'h0, cur_end};
			if (adc_end && adc_ch == bgm_pkg::CH_VOLT)
				volt_ff <= adc_data[11:0];
		end
	end
	// ****************
	// Assertions
	// ****************
	AST_VT_LEN: assert property (adc_end && adc_ch != bgm_pkg::CH_CUR
		|-> age_ff >= VT_C - TICK_DIV && age_ff <= VT_C + TICK_DIV)
		else $error("short or long window");
	AST_CUR_LEN: assert property (adc_end && adc_ch == bgm_pkg::CH_CUR
		|-> age_ff >= CU_C - TICK_DIV && age_ff <= CU_C + TICK_DIV)
		else $error("current window length wrong");
	AST_VONLY_NO_CUR: assert property (adc_start && mode_ff && $past(mode_ff, 2)
		|-> adc_ch != bgm_pkg::CH_CUR) else $error("current in voltage mode");
	AST_MIX_NEXT: assert property (adc_end && adc_ch == bgm_pkg::CH_VOLT && !mode_ff
		|-> ##[1:2] adc_start) else $error("mixed mode converter left idle");
	AST_CC_RB: assert property (reg_wr && reg_addr == bgm_pkg::ADDR_CC_CNF
		##1 reg_addr == bgm_pkg::ADDR_CC_CNF |=> reg_rdata == $past(reg_wdata, 2))
		else $error("scale register readback");
	AST_VM_RB: assert property (reg_wr && reg_addr == bgm_pkg::ADDR_VM_CNF
		##1 reg_addr == bgm_pkg::ADDR_VM_CNF
		|=> reg_rdata == ($past(reg_wdata, 2) & 16'h0FFF)) else $error("parameter readback");
	AST_VOLT_RD: assert property (reg_addr == bgm_pkg::ADDR_VOLT && !adc_end
		|=> reg_rdata[11:0] == volt_ff) else $error("voltage result");
	AST_COUNT_RD: assert property (reg_addr == bgm_pkg::ADDR_COUNT && !adc_end && !reg_wr
		|=> reg_rdata == cnt_ff) else $error("conversion count");
	AST_ACC_RD: assert property (reg_addr == bgm_pkg::ADDR_ACC_LO && !adc_end && !reg_wr
		|=> reg_rdata == acc_ff[15:0]) else $error("accumulator low half");
	// Main scenarios reached
	cover property (cur_end);
	cover property (adc_end && adc_ch == bgm_pkg::CH_TEMP);
	cover property (chg);
endmodule
bind bgm_core bgm_props #(.TICK_DIV(TICK_DIV), .VT_TICKS(VT_TICKS), .CUR_TICKS(CUR_TICKS))
	u_props (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_start(adc_start),
	.adc_ch(adc_ch), .adc_end(adc_end), .adc_data(adc_data));
`default_nettype wire

// ---- bgm_fe_model.sv ----
// Converter front end model answering the core.
// Assumes the bench sets the value of each channel.
`timescale 1ns/10ps
`default_nettype none
module bgm_fe_model (
	input wire logic	clock,		// Clock
	input wire logic	adc_start,	// Start pulse
	input wire logic [1:0]	adc_ch,		// Channel
	input wire logic	adc_end,	// End pulse
	input wire logic [15:0]	volt_v,		// Voltage result
	input wire logic [15:0]	temp_v,		// Temperature result
	input wire logic [15:0]	cur_v,		// Current result
	output logic [15:0]	adc_data	// Result bus
);
	logic [1:0]	ch_ff = 2'h0;
	logic [15:0]	res;
	// Channel held from the start pulse
	always @(posedge clock)
		if (adc_start)
			ch_ff <= adc_ch;
	// Off the end pulse the bus shows the inverse, never a stale result
	assign res = ch_ff == bgm_pkg::CH_VOLT ? volt_v : ch_ff == bgm_pkg::CH_TEMP ? temp_v : cur_v;
	assign adc_data = adc_end ? res : ~res;
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the gauge core.
// Assumes the core, its checker and the front end model.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam int DIV = 4;
	localparam int PC = 256 * DIV;
	logic		clock, nrst, reg_wr, adc_start, adc_end;
	logic [4:0]	reg_addr;
	logic [1:0]	adc_ch;
	logic [15:0]	reg_wdata, reg_rdata, adc_data;
	logic [15:0]	cc_soc, vm_soc, volt_v, temp_v, cur_v;
	int		miscompares, n_compared, n_v, n_t, n_c, n_e;
	bgm_core #(.TICK_DIV(DIV), .PERIOD_TICKS(256), .VT_TICKS(16), .CUR_TICKS(32)) dut (
		.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_start(adc_start),
		.adc_ch(adc_ch), .adc_end(adc_end), .adc_data(adc_data),
		.cc_soc(cc_soc), .vm_soc(vm_soc));
	bgm_fe_model u_fe (.clock(clock), .adc_start(adc_start), .adc_ch(adc_ch),
		.adc_end(adc_end), .volt_v(volt_v), .temp_v(temp_v), .cur_v(cur_v),
		.adc_data(adc_data));
	// ****************
	// Clock and tallies
	// ****************
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Pulses are counted at the edge that ends them
	always @(posedge clock)
	begin
		n_v += int'(adc_start && adc_ch == bgm_pkg::CH_VOLT);
		n_t += int'(adc_start && adc_ch == bgm_pkg::CH_TEMP);
		n_c += int'(adc_start && adc_ch == bgm_pkg::CH_CUR);
		n_e += int'(adc_end && adc_ch == bgm_pkg::CH_CUR);
	end
	// ****************
	// Tasks
	// ****************
	task automatic check(input string nm, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask
	// Data stands one cycle after the address
	task automatic rd(input logic [4:0] a, input logic [15:0] m, e, input string nm);
		@(negedge clock);
		reg_addr = a;
		@(negedge clock);
		check(nm, reg_rdata & m, e);
	endtask
	// Bounded wait; one more cycle lets the tally take the pulse
	task automatic wait_ev(input logic [1:0] ch, input logic st);
		int k;
		k = 0;
		@(negedge clock);
		while (!((st ? adc_start : adc_end) && adc_ch === ch) && k < 9000)
		begin
			@(negedge clock);
			k++;
		end
		@(negedge clock);
		check("wait", 16'(k < 9000), 16'h0001);
	endtask
	// Three and a half periods from a voltage start
	task automatic window(input int lo, hi, input string nm);
		wait_ev(bgm_pkg::CH_VOLT, 1'b1);
		n_v = 0;
		n_t = 0;
		n_c = 0;
		repeat (PC * 7 / 2) @(negedge clock);
		check({nm, " volt"}, 16'(n_v), 16'h0003);
		check({nm, " temp"}, 16'(n_t), 16'h0001);
		check({nm, " cur"}, 16'(n_c >= lo && n_c <= hi), 16'h0001);
		$display("test %s done", nm);
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog well past the expected run of about 9500 cycles
	initial
	begin
		repeat (40000) @(posedge clock);
		miscompares++;
		end_of_test;
	end
	// ****************
	// Tests
	// ****************
	initial
	begin
		{reg_addr, reg_wr, reg_wdata, nrst} = '0;
		{n_v, n_t, n_c, n_e, miscompares, n_compared} = '0;
		{volt_v, temp_v, cur_v} = {16'h07A3, 16'h00E7, 16'h3FFD};
		{cc_soc, vm_soc} = {16'h1000, 16'h1010};
		repeat (5) @(negedge clock);
		nrst = 1'b1;
		rd(bgm_pkg::ADDR_MODE, 16'hFFFF, 16'h0001, "mode");
		rd(bgm_pkg::ADDR_CC_CNF, 16'hFFFF, 16'h018B, "scale");
		rd(bgm_pkg::ADDR_VM_CNF, 16'hFFFF, 16'h0141, "param");
		rd(5'h0F, 16'hFFFF, 16'h0000, "unmapped");
		wr(bgm_pkg::ADDR_CC_CNF, 16'hA5C3);
		rd(bgm_pkg::ADDR_CC_CNF, 16'hFFFF, 16'hA5C3, "scale");
		wr(bgm_pkg::ADDR_VM_CNF, 16'hFFFF);
		rd(bgm_pkg::ADDR_VM_CNF, 16'hFFFF, 16'h0FFF, "param");
		$display("test reset values done");
		window(0, 0, "voltage only");
		rd(bgm_pkg::ADDR_VOLT, 16'h0FFF, 16'h07A3, "volt");
		rd(bgm_pkg::ADDR_TEMP, 16'h00FF, 16'h00E7, "temp");
		rd(bgm_pkg::ADDR_OCV, 16'hFFFF, 16'h07A3, "ocv");
		wr(5'h17, 16'h0005);
		rd(bgm_pkg::ADDR_OCV, 16'hFFFF, 16'h07A8, "ocv adj");
		rd(bgm_pkg::ADDR_COUNT, 16'hFFFF, 16'h0000, "count");
		wr(bgm_pkg::ADDR_MODE, 16'h0000);
		window(22, 25, "mixed");
		wait_ev(bgm_pkg::CH_CUR, 1'b0);
		rd(bgm_pkg::ADDR_COUNT, 16'hFFFF, 16'(n_e), "count");
		rd(bgm_pkg::ADDR_ACC_LO, 16'hFFFF, 16'(-3 * n_e), "acc lo");
		rd(bgm_pkg::ADDR_ACC_HI, 16'hFFFF, 16'hFFFF, "acc hi");
		rd(bgm_pkg::ADDR_CUR, 16'h3FFF, 16'h3FFD, "current");
		wr(bgm_pkg::ADDR_CHARGE, 16'h4000);
		rd(bgm_pkg::ADDR_COUNT, 16'hFFFF, 16'h0000, "restart count");
		rd(bgm_pkg::ADDR_ACC_LO, 16'hFFFF, 16'h0000, "restart acc");
		$display("test accumulate done");
		wr(bgm_pkg::ADDR_ACC_CC, 16'h0055);
		wr(bgm_pkg::ADDR_ACC_VM, 16'h00AA);
		rd(bgm_pkg::ADDR_ACC_CC, 16'hFFFF, 16'h0055, "acc cc seed");
		wr(bgm_pkg::ADDR_MODE, 16'h0006);
		rd(bgm_pkg::ADDR_MODE, 16'h0007, 16'h0000, "clear bits");
		rd(bgm_pkg::ADDR_ACC_CC, 16'hFFFF, 16'h0000, "acc cc");
		rd(bgm_pkg::ADDR_ACC_VM, 16'hFFFF, 16'h0000, "acc vm");
		wait_ev(bgm_pkg::CH_VOLT, 1'b0);
		rd(bgm_pkg::ADDR_VM_ADJ, 16'hFFFF, 16'hFFF0, "vm now");
		wr(bgm_pkg::ADDR_CC_ADJ, 16'h0123);
		rd(bgm_pkg::ADDR_CC_ADJ, 16'hFFFF, 16'h0123, "cc now");
		cur_v = 16'h0400;
		wait_ev(bgm_pkg::CH_CUR, 1'b0);
		rd(bgm_pkg::ADDR_CUR, 16'h3FFF, 16'h3FFD, "current held");
		rd(bgm_pkg::ADDR_MODE, 16'h0008, 16'h0008, "method");
		rd(bgm_pkg::ADDR_ACC_CC, 16'hFFFF, 16'h0123, "acc cc");
		rd(bgm_pkg::ADDR_ACC_VM, 16'hFFFF, 16'hFFF0, "acc vm");
		$display("test method switch done");
		nrst = 1'b0;
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		rd(bgm_pkg::ADDR_MODE, 16'hFFFF, 16'h0001, "mode after reset");
		rd(bgm_pkg::ADDR_CC_CNF, 16'hFFFF, 16'h018B, "scale after reset");
		rd(bgm_pkg::ADDR_COUNT, 16'hFFFF, 16'h0000, "count after reset");
		$display("test mid-run reset done");
		end_of_test;
	end
endmodule
`default_nettype wire
